// File: verilog/scan_port.v
// boundary-scan test port with a strap-selected bus chain width
`timescale 1ns/10ps
`include "scan_port_regs.vh"

// Operation
// [RULE_01] Each test clock rise shifts input into the instruction or the selected data register.
// [RULE_02] The serial output changes on the test clock fall with the bit shifted out.
// [RULE_03] The serial output is not driven while nothing is being shifted out.
// [RULE_04] All test logic runs from the test clock, kept by the tester at 40 to 60 percent duty; here it runs from the system clock and samples the test clock.
// [RULE_05] The controller samples mode select on the test clock rise to advance its state.
// [RULE_06] A low test reset resets the test logic independently of the processor.
// [RULE_07] In normal operation the system holds test reset low.
// [RULE_08] While test reset is low the serial output is not driven.
// [RULE_09] With the width strap low only bus bits 31..0 are in the boundary chain.
// [RULE_10] With the width strap high all 64 bus bits are in the chain.
// [RULE_11] An open width strap reads low, giving the 32-bit chain.
// [RULE_12] A low or open test reset enable holds the controller in reset.
// [RULE_13] A high test reset enable makes test reset the main reset control.
// [RULE_14] In 32-bit configuration the upper bus half carries nothing.
// [RULE_15] The controller is the sixteen-state machine, reset by test reset or a low enable.
// [RULE_16] After reset the instruction selects the single-bit bypass path.
module scan_port (
  // system clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // test pins
  input wire tck_in,
  input wire tms_in,
  input wire tdi_in,
  input wire trst_n_in,
  output reg tdo_out,
  output reg tdo_oe_out,
  // straps
  input wire scan_width_select_n_in,
  input wire test_reset_enable_in,
  // core side of the system address/data bus
  input wire [63:0] core_bus_data_in,
  input wire [63:0] core_bus_oe_in,
  output wire [63:0] core_bus_data_out,
  // system address/data bus pads
  input wire [63:0] system_addr_data_bus_in,
  output reg [63:0] system_addr_data_bus_out,
  output reg [63:0] system_addr_data_bus_oe_out
);
  // -----------------------------------------------------------
  // synchronisers: two flops for every pin before use
  // -----------------------------------------------------------
  reg [4:0] pin_meta;
  reg [4:0] pin_sync;
  reg tck_prev;
  reg [63:0] bus_meta;
  reg [63:0] bus_sync;

  // [RULE_04] test clock seen through the system clock
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      tck_prev <= 1'b0;
      bus_meta <= 64'h0000000000000000;
      bus_sync <= 64'h0000000000000000;
    end else begin
      pin_meta <= {tck_in, tms_in, tdi_in, trst_n_in, test_reset_enable_in};
      pin_sync <= pin_meta;
      tck_prev <= pin_sync[4];
      bus_meta <= system_addr_data_bus_in;
      bus_sync <= bus_meta;
    end
  end

  wire tck_s = pin_sync[4];
  wire tms_s = pin_sync[3];
  wire tdi_s = pin_sync[2];
  wire trst_n_s = pin_sync[1];
  wire tre_s = pin_sync[0];
  wire tck_rise = tck_s & ~tck_prev;
  wire tck_fall = ~tck_s & tck_prev;

  // [RULE_06] test reset from pins only, no processor state
  // [RULE_12] low enable pins the controller in reset
  // [RULE_13] high enable hands control to test reset
  wire tap_reset = ~rst_n_in | ~tre_s | ~trst_n_s;

  // -----------------------------------------------------------
  // width strap, resampled every system cycle outside system reset
  // -----------------------------------------------------------
  reg width_meta;
  reg wide_chain;

  // [RULE_11] open strap is pulled low at the pad, so it reads narrow
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      width_meta <= 1'b0;
      wide_chain <= 1'b0;
    end else begin
      width_meta <= scan_width_select_n_in;
      wide_chain <= width_meta;
    end
  end

  // -----------------------------------------------------------
  // controller
  // -----------------------------------------------------------
  wire st_reset;
  wire cap_dr;
  wire sh_dr;
  wire upd_dr;
  wire cap_ir;
  wire sh_ir;
  wire upd_ir;

  scan_tap_fsm u_fsm (
    .clk_sys_in(clk_sys_in),
    .tap_reset_in(tap_reset),
    .tck_rise_in(tck_rise),
    .tms_in(tms_s),
    .test_reset_out(st_reset),
    .capture_dr_out(cap_dr),
    .shift_dr_out(sh_dr),
    .update_dr_out(upd_dr),
    .capture_ir_out(cap_ir),
    .shift_ir_out(sh_ir),
    .update_ir_out(upd_ir)
  );

  // -----------------------------------------------------------
  // instruction register and its shift stage
  // -----------------------------------------------------------
  reg [`IR_WIDTH-1:0] ir_shift;
  reg [`IR_WIDTH-1:0] ir;

  // [RULE_16] bypass after reset
  always @(posedge clk_sys_in) begin
    if (tap_reset) begin
      ir_shift <= `IR_RESET_VALUE;
      ir <= `IR_RESET_VALUE;
    end else if (tck_rise) begin
      if (st_reset) begin
        ir <= `IR_RESET_VALUE;
      end else if (cap_ir) begin
        ir_shift <= `IR_CAPTURE_VALUE;
      end else if (sh_ir) begin
        // [RULE_01] shift into instruction
        ir_shift <= {tdi_s, ir_shift[`IR_WIDTH-1:1]};
      end else if (upd_ir) begin
        ir <= ir_shift;
      end
    end
  end

  wire sel_boundary = (ir == `INSN_EXTEST) || (ir == `INSN_SAMPLE);
  wire extest = (ir == `INSN_EXTEST);

  // -----------------------------------------------------------
  // data registers: bypass bit and boundary chain
  // -----------------------------------------------------------
  reg bypass_bit;
  reg [63:0] bsr;
  reg [63:0] bsr_upd;

  // [RULE_09] narrow chain uses bits 31..0 only
  // [RULE_10] wide chain uses all 64 bits
  // [RULE_14] upper half zero when narrow
  function [63:0] chain_mask;
    input wide;
    begin
      chain_mask = wide ? 64'hFFFFFFFFFFFFFFFF : 64'h00000000FFFFFFFF;
    end
  endfunction

  always @(posedge clk_sys_in) begin
    if (tap_reset) begin
      bypass_bit <= 1'b0;
      bsr <= 64'h0000000000000000;
      bsr_upd <= 64'h0000000000000000;
    end else if (tck_rise) begin
      if (cap_dr) begin
        bypass_bit <= 1'b0;
        if (sel_boundary) begin
          bsr <= bus_sync & chain_mask(wide_chain);
        end
      end else if (sh_dr) begin
        // [RULE_01] shift into selected data register
        bypass_bit <= tdi_s;
        if (sel_boundary) begin
          if (wide_chain) begin
            bsr <= {tdi_s, bsr[`BUS_WIDE_MSB:1]};
          end else begin
            bsr <= {32'h00000000, tdi_s, bsr[`BUS_NARROW_MSB:1]};
          end
        end
      end else if (upd_dr && sel_boundary) begin
        bsr_upd <= bsr & chain_mask(wide_chain);
      end
    end
  end

  // -----------------------------------------------------------
  // serial output, changed on the test clock fall
  // -----------------------------------------------------------
  wire dr_out_bit = sel_boundary ? bsr[0] : bypass_bit;

  // [RULE_02] update on the falling edge
  // [RULE_03] released when not shifting
  // [RULE_08] released while test reset is low
  always @(posedge clk_sys_in) begin
    if (tap_reset) begin
      tdo_out <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_out <= sh_ir ? ir_shift[0] : (sh_dr ? dr_out_bit : 1'b0);
      tdo_oe_out <= sh_ir | sh_dr;
    end
  end

  // -----------------------------------------------------------
  // bus pads: core path, or boundary cells under external test
  // -----------------------------------------------------------
  // pads are registered, so the core path costs one system cycle
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      system_addr_data_bus_out <= 64'h0000000000000000;
      system_addr_data_bus_oe_out <= 64'h0000000000000000;
    end else if (extest && !tap_reset) begin
      // [RULE_14] upper half undriven in narrow mode
      system_addr_data_bus_out <= bsr_upd & chain_mask(wide_chain);
      system_addr_data_bus_oe_out <= chain_mask(wide_chain);
    end else begin
      system_addr_data_bus_out <= core_bus_data_in & chain_mask(wide_chain);
      system_addr_data_bus_oe_out <= core_bus_oe_in & chain_mask(wide_chain);
    end
  end

  // core sees the synchronised pad level, upper half blanked when narrow
  assign core_bus_data_out = bus_sync & chain_mask(wide_chain);
endmodule

// File: shared/scan_port_regs.vh
// constants for the boundary-scan test port
`ifndef SCAN_PORT_REGS_VH
`define SCAN_PORT_REGS_VH

// ------------------------------------------------------------
// instruction register
// ------------------------------------------------------------
`define IR_WIDTH 4
`define INSN_EXTEST 4'h0
`define INSN_SAMPLE 4'h1
`define INSN_BYPASS 4'hF
`define IR_RESET_VALUE 4'hF
// fixed pattern captured into the instruction register
`define IR_CAPTURE_VALUE 4'h1

// ------------------------------------------------------------
// boundary chain over the system address/data bus
// ------------------------------------------------------------
`define BUS_WIDTH 64
`define BUS_NARROW_WIDTH 32
`define BUS_NARROW_MSB 31
`define BUS_WIDE_MSB 63

// ------------------------------------------------------------
// timing: nominal test clock duty cycle limits, percent, and synchroniser depth in stages
// ------------------------------------------------------------
`define TCK_DUTY_MIN_PCT 40
`define TCK_DUTY_MAX_PCT 60
`define SYNC_STAGES 2

`endif

// File: verilog/scan_tap_fsm.v
// sixteen-state test access port controller
`timescale 1ns/10ps
module scan_tap_fsm (
  // clock and reset
  input wire clk_sys_in,
  input wire tap_reset_in,
  // sampled test pins
  input wire tck_rise_in,
  input wire tms_in,
  // decoded state flags
  output wire test_reset_out,
  output wire capture_dr_out,
  output wire shift_dr_out,
  output wire update_dr_out,
  output wire capture_ir_out,
  output wire shift_ir_out,
  output wire update_ir_out
);
  localparam [3:0] ST_RESET = 4'hF;
  localparam [3:0] ST_IDLE = 4'hC;
  localparam [3:0] ST_SEL_DR = 4'h7;
  localparam [3:0] ST_CAP_DR = 4'h6;
  localparam [3:0] ST_SH_DR = 4'h2;
  localparam [3:0] ST_EX1_DR = 4'h1;
  localparam [3:0] ST_PA_DR = 4'h3;
  localparam [3:0] ST_EX2_DR = 4'h0;
  localparam [3:0] ST_UPD_DR = 4'h5;
  localparam [3:0] ST_SEL_IR = 4'h4;
  localparam [3:0] ST_CAP_IR = 4'hE;
  localparam [3:0] ST_SH_IR = 4'hA;
  localparam [3:0] ST_EX1_IR = 4'h9;
  localparam [3:0] ST_PA_IR = 4'hB;
  localparam [3:0] ST_EX2_IR = 4'h8;
  localparam [3:0] ST_UPD_IR = 4'hD;

  reg [3:0] state;
  reg [3:0] next_state;

  // -----------------------------------------------------------
  // next state from the sampled mode select
  // -----------------------------------------------------------
  always @* begin
    case (state)
      ST_RESET: next_state = tms_in ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = tms_in ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms_in ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: next_state = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = tms_in ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: next_state = tms_in ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_state = tms_in ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = tms_in ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms_in ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_state = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: next_state = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = tms_in ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: next_state = tms_in ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_state = tms_in ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = tms_in ? ST_SEL_DR : ST_IDLE;
      default: next_state = ST_RESET;
    endcase
  end

  // -----------------------------------------------------------
  // state register, advanced only on a test clock rising edge
  // -----------------------------------------------------------
  // [RULE_05] sample mode select
  always @(posedge clk_sys_in) begin
    if (tap_reset_in) begin
      state <= ST_RESET;
    end else if (tck_rise_in) begin
      state <= next_state;
    end
  end

  // [RULE_15] standard state decode
  assign test_reset_out = (state == ST_RESET);
  assign capture_dr_out = (state == ST_CAP_DR);
  assign shift_dr_out = (state == ST_SH_DR);
  assign update_dr_out = (state == ST_UPD_DR);
  assign capture_ir_out = (state == ST_CAP_IR);
  assign shift_ir_out = (state == ST_SH_IR);
  assign update_ir_out = (state == ST_UPD_IR);
endmodule

// File: tb/scan_port_sva.sv
// assertions on the boundary-scan test port pins
`timescale 1ns/10ps
module scan_port_sva (
  // clock and resets
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire trst_n_in,
  // test pins and straps
  input wire tck_in,
  input wire tdo_out,
  input wire tdo_oe_out,
  input wire scan_width_select_n_in,
  input wire test_reset_enable_in,
  // bus outputs
  input wire [63:0] core_bus_data_out,
  input wire [63:0] system_addr_data_bus_out,
  input wire [63:0] system_addr_data_bus_oe_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // six samples cover the pin synchronisers plus the output register
  sequence trst_held; (!trst_n_in)[*6]; endsequence
  sequence gate_held; (!test_reset_enable_in)[*6]; endsequence
  sequence narrow_held; (!scan_width_select_n_in)[*6]; endsequence
  tdo_quiet_reset_a: assert property (trst_held |-> !tdo_oe_out && !tdo_out)
    else $error("tdo driven under test reset");
  tdo_quiet_gate_a: assert property (gate_held |-> !tdo_oe_out)
    else $error("tdo driven with reset enable low");
  narrow_upper_a: assert property (narrow_held |->
    system_addr_data_bus_oe_out[63:32] == 0 && system_addr_data_bus_out[63:32] == 0
    && core_bus_data_out[63:32] == 0)
    else $error("upper bus half active in narrow mode");
  tdo_after_fall_a: assert property ($changed(tdo_out) |-> !tck_in && !$past(tck_in, 2))
    else $error("tdo changed away from a tck fall");
  oe_rise_low_a: assert property ($rose(tdo_oe_out) |-> !tck_in)
    else $error("tdo enable rose while tck high");
  oe_fall_low_a: assert property ($fell(tdo_oe_out) && trst_n_in && test_reset_enable_in
    |-> !tck_in) else $error("tdo enable fell while tck high");
  rise_no_tdo_a: assert property ($rose(tck_in) |-> ##1 $stable(tdo_out)[*3])
    else $error("tdo moved after a tck rise");
  oe_from_tck_a: assert property ($rose(tdo_oe_out) |-> $past(tck_in, 6))
    else $error("tdo enable rose without a tck fall");
endmodule
bind scan_port scan_port_sva chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .trst_n_in(trst_n_in), .tck_in(tck_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
  .scan_width_select_n_in(scan_width_select_n_in), .test_reset_enable_in(test_reset_enable_in),
  .core_bus_data_out(core_bus_data_out), .system_addr_data_bus_out(system_addr_data_bus_out),
  .system_addr_data_bus_oe_out(system_addr_data_bus_oe_out));

// File: tb/tap_tester.sv
// external tester model driving the serial test pins
`timescale 1ns/10ps
module tap_tester (
  // serial test pins
  output reg tck_out,
  output reg tms_out,
  output reg tdi_out,
  input wire tdo_in,
  input wire tdo_oe_in
);
  reg seen;
  event bit_seen;
  // tck idles low between frames
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // tms set half a period early
  task step(input reg m, input reg d);
    begin
      tms_out = m;
      tdi_out = d;
      #62.5;
      // only a driven tdo is taken; a released line holds nothing useful
      if (tdo_oe_in === 1'b1) begin
        seen = tdo_in;
        -> bit_seen;
      end
      tck_out = 1'b1;
      #62.5;
      tck_out = 1'b0;
    end
  endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
`include "scan_port_regs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top;
  reg clk_sys_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg trst_n_in = 1'b0;
  reg width_n = 1'b0;
  reg reset_en = 1'b0;
  reg [63:0] core_d = 64'h0, core_oe = 64'h0, pads = 64'h0, din, mask;
  reg exp_q[$];
  reg exp_bit;
  int fail_count = 0;
  int total_checks = 0;
  int seed;
  wire tck, tms, tdi, tdo, tdo_oe;
  wire [63:0] core_q, bus_q, bus_oe;
  always #5 clk_sys_in = ~clk_sys_in;
  scan_port dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .trst_n_in(trst_n_in), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
    .scan_width_select_n_in(width_n), .test_reset_enable_in(reset_en),
    .core_bus_data_in(core_d), .core_bus_oe_in(core_oe), .core_bus_data_out(core_q),
    .system_addr_data_bus_in(pads), .system_addr_data_bus_out(bus_q),
    .system_addr_data_bus_oe_out(bus_oe));
  tap_tester tester (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo),
    .tdo_oe_in(tdo_oe));
  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // tck steps with tms taken lsb first from m
  task walk(input reg [7:0] m, input int n);
    for (int i = 0; i < n; i++) tester.step(m[i], 1'b0);
  endtask
  // from idle: shift total bits, the first len from the capture, then din echoed back
  task scan(input reg ir, input int total, input int len, input reg [63:0] d,
    input reg [63:0] cap);
    begin
      walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      for (int i = 0; i < total; i++) begin
        exp_q.push_back(i < len ? cap[i] : d[i - len]);
        tester.step(i == total - 1, i < 64 ? d[i] : 1'b0);
      end
      walk(8'h01, 2);
    end
  endtask
  task settle;
    repeat (8) @(posedge clk_sys_in);
  endtask
  // every tdo bit the tester takes is matched against the oldest note
  always @(tester.bit_seen) begin
    if (exp_q.size() == 0) begin
      fail_count++;
      $display("wrong value tdo exp none got %0h", tester.seen);
    end else begin
      exp_bit = exp_q.pop_front();
      `CHK("tdo", exp_bit, tester.seen)
    end
  end
  initial begin
    #400000;
    fail_count++;
    $display("timeout");
    test_done;
  end
  initial begin
    seed = $urandom(18740);
    settle;
    rst_n_in <= 1'b1;
    trst_n_in <= 1'b1;
    reset_en <= 1'b1;
    settle;
    `CHK("tdo_oe", 1'b0, tdo_oe)
    walk(8'h1F, 6);
    din = {$urandom, $urandom};
    scan(0, 8, 1, din, 64'h0);
    $display("test bypass done");
    for (int w = 0; w < 2; w++) begin
      @(posedge clk_sys_in);
      width_n <= w[0];
      pads <= {$urandom, $urandom};
      core_d <= {$urandom, $urandom};
      core_oe <= {$urandom, $urandom};
      mask = w ? 64'hFFFFFFFFFFFFFFFF : 64'h00000000FFFFFFFF;
      din = {$urandom, $urandom};
      scan(1, 4, 4, `INSN_SAMPLE, `IR_CAPTURE_VALUE);
      settle;
      `CHK("pad_oe", core_oe & mask, bus_oe)
      `CHK("pad_out", core_d & mask, bus_q)
      `CHK("core_in", pads & mask, core_q)
      scan(0, w ? 68 : 36, w ? 64 : 32, din, pads);
      scan(1, 4, 4, `INSN_EXTEST, `IR_CAPTURE_VALUE);
      settle;
      `CHK("ext_out", (din >> 4) & mask, bus_q)
      `CHK("ext_oe", mask, bus_oe)
      $display("test width %0d done", w);
    end
    walk(8'h03, 4);
    exp_q.push_back(1'b1);
    tester.step(1'b0, 1'b0);
    @(posedge clk_sys_in);
    trst_n_in <= 1'b0;
    settle;
    `CHK("tdo_oe", 1'b0, tdo_oe)
    walk(8'h03, 5);
    @(posedge clk_sys_in);
    trst_n_in <= 1'b1;
    settle;
    walk(8'h00, 1);
    scan(0, 2, 1, din, 64'h0);
    $display("test trst done");
    @(posedge clk_sys_in);
    reset_en <= 1'b0;
    settle;
    walk(8'h03, 5);
    `CHK("tdo_oe", 1'b0, tdo_oe)
    @(posedge clk_sys_in);
    reset_en <= 1'b1;
    settle;
    walk(8'h00, 1);
    scan(0, 2, 1, din, 64'h0);
    `CHK("pending", 32'd0, exp_q.size())
    $display("test enable done");
    test_done;
  end
endmodule
